//--- verilog/variable_transfer_areas.sv
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`default_nettype none
module variable_transfer_areas #(
  parameter int MEM_WORDS = 256,
  parameter int TIMEOUT = transfer_areas_pkg::TIMEOUT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [transfer_areas_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [transfer_areas_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [transfer_areas_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [transfer_areas_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic comp_req_valid,
  input wire logic comp_req_ready,
  output logic comp_req_write,
  output logic comp_req_opcmd,
  output logic [7:0] comp_req_type,
  output logic [15:0] comp_req_addr,
  output logic [31:0] comp_req_data,
  input wire logic comp_rsp_valid,
  input wire logic [7:0] comp_rsp_end_code,
  input wire logic [15:0] comp_rsp_code,
  input wire logic [15:0] comp_rsp_status,
  input wire logic [31:0] comp_rsp_data
);
  import transfer_areas_pkg::*;
  localparam int IW = $clog2(MEM_WORDS);

  // Words of the host data memory area; software loads lists and areas here.
  logic [15:0] host_data_memory_area [MEM_WORDS];

  function automatic logic [IW-1:0] word_at(input logic [15:0] base, input logic [5:0] ofs);
    word_at = IW'(base + {10'h000, ofs});
  endfunction : word_at

  state_type state_reg;
  logic is_write_reg, op_phase_reg, opcmd_en_reg, syntax_err_reg, comm_err_reg;
  logic [3:0] var_reg, count_reg;
  logic [5:0] zero_reg;
  logic [15:0] def_reg, area_reg, code_reg, rd_def_reg, wr_def_reg;
  logic [31:0] data_reg, timer_reg;
  logic aw_hold, w_hold;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // Definition list decode.
  wire logic [15:0] count_word = host_data_memory_area[word_at(def_reg, DEF_COUNT)];
  wire logic [15:0] opcmd_word = host_data_memory_area[word_at(def_reg, DEF_OPCMD)];
  wire logic [15:0] area_word = host_data_memory_area[word_at(def_reg, DEF_AREA)];
  wire logic [5:0] var2 = {1'b0, var_reg, 1'b0};
  wire logic [15:0] type_word = host_data_memory_area[word_at(def_reg, var2 + 6'd1)];
  wire logic [15:0] vaddr_word = host_data_memory_area[word_at(def_reg, var2 + 6'd2)];
  wire logic [15:0] src_lo = host_data_memory_area[word_at(area_reg, var2)];
  wire logic [15:0] src_hi = host_data_memory_area[word_at(area_reg, var2 + 6'd1)];
  wire logic [15:0] cmd_word = host_data_memory_area[word_at(area_reg, AREA_STATUS)];
  wire logic count_bcd = is_bcd(count_word) && count_word <= COUNT_MAX;
  wire logic count_ok = count_bcd && (is_write_reg || count_word >= RD_COUNT_MIN);
  wire logic opcmd_ok = !is_write_reg || opcmd_word == OPCMD_OFF || opcmd_word == OPCMD_ON;
  wire logic [15:0] area_bin = bcd_to_bin(area_word);
  wire logic area_ok = is_bcd(area_word) && ({16'h0000, area_bin} + 32'(AREA_SPAN) <= 32'(MEM_WORDS));
  wire logic header_ok = count_ok && opcmd_ok && area_ok;
  wire logic type_ok = type_word >= TYPE_MIN && type_word <= TYPE_MAX;
  wire logic [3:0] count_bin = 4'(bcd_to_bin(count_word));
  wire logic last_var = var_reg == count_reg;

  // Component exchange decode.
  wire logic rsp_take = state_reg == S_WAIT && comp_rsp_valid;
  wire logic end_err = comp_rsp_end_code != END_OK;
  wire logic rsp_fail = end_err || comp_rsp_code != CODE_OK;
  wire logic timed_out = state_reg == S_WAIT && !comp_rsp_valid && timer_reg == 32'(TIMEOUT - 1);
  wire logic [15:0] rsp_monitor = end_err ? {ERR_PREFIX, comp_rsp_end_code} : comp_rsp_code;
  wire logic more_writes = !last_var || (opcmd_en_reg && !op_phase_reg);

  // Engine memory write port.
  wire logic eng_we = (rsp_take && !is_write_reg && !op_phase_reg && !end_err) || state_reg == S_STORE_LO
    || state_reg == S_STORE_HI || state_reg == S_ZERO || state_reg == S_MONITOR;
  wire logic [IW-1:0] eng_wa = state_reg == S_WAIT ? word_at(area_reg, AREA_STATUS) :
    state_reg == S_STORE_LO ? word_at(area_reg, var2) :
    state_reg == S_STORE_HI ? word_at(area_reg, var2 + 6'd1) :
    state_reg == S_ZERO ? word_at(area_reg, zero_reg) : word_at(area_reg, AREA_MONITOR);
  wire logic [15:0] eng_wd = state_reg == S_WAIT ? comp_rsp_status :
    state_reg == S_STORE_LO ? data_reg[15:0] :
    state_reg == S_STORE_HI ? data_reg[31:16] :
    state_reg == S_ZERO ? 16'h0000 : code_reg;

  // AXI4-Lite write path: address and data may arrive in either order.
  wire logic aw_now = aw_hold || (s_axi_awvalid && s_axi_awready);
  wire logic w_now = w_hold || (s_axi_wvalid && s_axi_wready);
  wire logic do_write = aw_now && w_now;
  wire logic [ADDR_W-1:0] wr_addr = aw_hold ? aw_addr_reg : s_axi_awaddr;
  wire logic [31:0] wr_data = w_hold ? w_data_reg : s_axi_wdata;
  wire logic [3:0] wr_strb = w_hold ? w_strb_reg : s_axi_wstrb;
  wire logic busy = state_reg != S_IDLE;
  wire logic wr_is_mem = wr_addr >= MEM_OFS && 32'(wr_addr - MEM_OFS) < 32'(MEM_WORDS * 4);
  wire logic wr_is_reg = wr_addr == CTRL_OFS || wr_addr == RD_DEF_OFS || wr_addr == WR_DEF_OFS;
  wire logic [IW-1:0] wr_idx = IW'((wr_addr - MEM_OFS) >> 2);
  // Memory writes are refused while a transfer runs, so the engine never races software.
  wire logic axi_mem_we = do_write && wr_is_mem && !busy && ce;
  wire logic [15:0] old_word = host_data_memory_area[wr_idx];
  wire logic [15:0] axi_wd = {wr_strb[1] ? wr_data[15:8] : old_word[15:8], wr_strb[0] ? wr_data[7:0] : old_word[7:0]};
  wire logic ctrl_wr = do_write && wr_addr == CTRL_OFS && wr_strb[0] && !busy;
  wire logic start_rd = ctrl_wr && wr_data[CTRL_START_RD_BIT];
  wire logic start_wr = ctrl_wr && wr_data[CTRL_START_WR_BIT] && !wr_data[CTRL_START_RD_BIT];
  wire logic [1:0] wr_resp = wr_is_reg ? RESP_OKAY : wr_is_mem ? (busy ? RESP_SLVERR : RESP_OKAY) : RESP_DECERR;

  // AXI4-Lite read path.
  wire logic rd_is_mem = s_axi_araddr >= MEM_OFS && 32'(s_axi_araddr - MEM_OFS) < 32'(MEM_WORDS * 4);
  wire logic [IW-1:0] rd_idx = IW'((s_axi_araddr - MEM_OFS) >> 2);
  wire logic [31:0] status_word = {code_reg, 13'h0000, comm_err_reg, syntax_err_reg, busy};
  wire logic [31:0] rd_value = rd_is_mem ? {16'h0000, host_data_memory_area[rd_idx]} :
    s_axi_araddr == RD_DEF_OFS ? {16'h0000, rd_def_reg} :
    s_axi_araddr == WR_DEF_OFS ? {16'h0000, wr_def_reg} :
    s_axi_araddr == STATUS_OFS ? status_word : 32'h0000_0000;
  wire logic rd_known = rd_is_mem || s_axi_araddr == CTRL_OFS || s_axi_araddr == RD_DEF_OFS
    || s_axi_araddr == WR_DEF_OFS || s_axi_araddr == STATUS_OFS;

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign comp_req_valid = state_reg == S_ISSUE;
  assign comp_req_write = is_write_reg;
  assign comp_req_opcmd = op_phase_reg;
  assign comp_req_type = op_phase_reg ? 8'h00 : type_word[7:0];
  assign comp_req_addr = op_phase_reg ? 16'h0000 : vaddr_word;
  assign comp_req_data = op_phase_reg ? {16'h0000, cmd_word} : is_write_reg ? {src_hi, src_lo} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (ce && (axi_mem_we || eng_we)) begin
      host_data_memory_area[axi_mem_we ? wr_idx : eng_wa] <= axi_mem_we ? axi_wd : eng_wd;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      rd_def_reg <= '0;
      wr_def_reg <= '0;
    end else if (ce) begin
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_resp;
        if (wr_addr == RD_DEF_OFS) begin
          rd_def_reg <= {wr_strb[1] ? wr_data[15:8] : rd_def_reg[15:8], wr_strb[0] ? wr_data[7:0] : rd_def_reg[7:0]};
        end
        if (wr_addr == WR_DEF_OFS) begin
          wr_def_reg <= {wr_strb[1] ? wr_data[15:8] : wr_def_reg[15:8], wr_strb[0] ? wr_data[7:0] : wr_def_reg[7:0]};
        end
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_known ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
      is_write_reg <= 1'b0;
      op_phase_reg <= 1'b0;
      opcmd_en_reg <= 1'b0;
      syntax_err_reg <= 1'b0;
      comm_err_reg <= 1'b0;
      var_reg <= '0;
      count_reg <= '0;
      zero_reg <= '0;
      def_reg <= '0;
      area_reg <= '0;
      code_reg <= CODE_OK;
      data_reg <= '0;
      timer_reg <= '0;
    end else if (ce) begin
      unique case (state_reg)
        S_IDLE: begin
          if (start_rd || start_wr) begin
            is_write_reg <= start_wr;
            def_reg <= start_wr ? wr_def_reg : rd_def_reg;
            op_phase_reg <= 1'b0;
            syntax_err_reg <= 1'b0;
            comm_err_reg <= 1'b0;
            var_reg <= '0;
            state_reg <= S_CHECK;
          end
        end
        S_CHECK: begin
          // The header and every type word are checked before the first exchange, so a bad list leaves memory untouched.
          if (var_reg == '0) begin
            if (!header_ok) begin
              syntax_err_reg <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              count_reg <= count_bin;
              area_reg <= area_bin;
              opcmd_en_reg <= is_write_reg && opcmd_word == OPCMD_ON;
              code_reg <= CODE_OK;
              // No variables: the command exchange is already the last one.
              var_reg <= count_bin == '0 ? 4'd0 : 4'd1;
              if (count_bin == '0) begin
                op_phase_reg <= opcmd_word == OPCMD_ON;
                state_reg <= opcmd_word == OPCMD_ON ? S_ISSUE : S_MONITOR;
              end
            end
          end else if (!type_ok) begin
            syntax_err_reg <= 1'b1;
            state_reg <= S_IDLE;
          end else if (last_var) begin
            var_reg <= 4'd1;
            state_reg <= S_ISSUE;
          end else begin
            var_reg <= var_reg + 4'd1;
          end
        end
        S_ISSUE: begin
          timer_reg <= '0;
          if (comp_req_ready) begin
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          timer_reg <= timer_reg + 32'd1;
          if (rsp_take) begin
            code_reg <= rsp_monitor;
            data_reg <= comp_rsp_data;
            if (rsp_fail) begin
              comm_err_reg <= 1'b1;
              zero_reg <= var2;
              state_reg <= is_write_reg ? S_MONITOR : S_ZERO;
            end else if (!is_write_reg) begin
              state_reg <= S_STORE_LO;
            end else if (more_writes) begin
              op_phase_reg <= last_var;
              var_reg <= last_var ? var_reg : var_reg + 4'd1;
              state_reg <= S_ISSUE;
            end else begin
              state_reg <= S_MONITOR;
            end
          end else if (timed_out) begin
            code_reg <= CODE_TIMEOUT;
            comm_err_reg <= 1'b1;
            zero_reg <= var2;
            state_reg <= is_write_reg ? S_MONITOR : S_ZERO;
          end
        end
        S_STORE_LO: state_reg <= S_STORE_HI;
        S_STORE_HI: begin
          var_reg <= var_reg + 4'd1;
          state_reg <= last_var ? S_MONITOR : S_ISSUE;
        end
        S_ZERO: begin
          zero_reg <= zero_reg + 6'd1;
          if (zero_reg == {1'b0, count_reg, 1'b1}) begin
            state_reg <= S_MONITOR;
          end
        end
        S_MONITOR: state_reg <= S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  type_range_a: assert property (ce && state_reg == S_CHECK && var_reg != '0 && !type_ok
    |=> state_reg == S_IDLE && syntax_err_reg) else $error("bad variable type not flagged");
  count_range_a: assert property (ce && state_reg == S_CHECK && var_reg == '0 && !count_ok
    |=> state_reg == S_IDLE && syntax_err_reg && $stable(code_reg)) else $error("bad item count not flagged");
  type_fetch_a: assert property (comp_req_valid && !comp_req_opcmd
    |-> comp_req_type == host_data_memory_area[word_at(def_reg, {1'b0, var_reg, 1'b0} + 6'd1)][7:0])
    else $error("type word taken from wrong offset");
  data_pair_a: assert property (ce && state_reg == S_STORE_LO
    |=> eng_we && eng_wa == word_at(area_reg, var2 + 6'd1) && eng_wd == data_reg[31:16] ##1 state_reg != S_STORE_HI)
    else $error("read value not stored low then high");
  status_copy_a: assert property (ce && rsp_take && !is_write_reg && !op_phase_reg && !end_err
    |-> eng_we && eng_wa == word_at(area_reg, AREA_STATUS)) else $error("status not copied");
  end_code_a: assert property (ce && rsp_take && end_err
    |=> code_reg == {ERR_PREFIX, $past(comp_rsp_end_code)} && comm_err_reg) else $error("end code not reported");
  timeout_a: assert property (ce && timed_out |=> code_reg == CODE_TIMEOUT) else $error("timeout code missing");
  zero_fill_a: assert property (state_reg == S_ZERO |-> eng_we && eng_wd == 16'h0000) else $error("zero fill wrong");
  write_abandon_a: assert property (ce && rsp_take && is_write_reg && rsp_fail
    |=> state_reg == S_MONITOR ##1 state_reg == S_IDLE && !comp_req_valid) else $error("write not abandoned");
  monitor_last_a: assert property (ce && state_reg == S_MONITOR
    |-> eng_wa == word_at(area_reg, AREA_MONITOR) && eng_wd == code_reg) else $error("monitor not written last");

  read_done_c: cover property (state_reg == S_STORE_HI && last_var ##1 state_reg == S_MONITOR);
  write_cmd_c: cover property (comp_req_valid && comp_req_opcmd && comp_req_ready);
  timeout_c: cover property (ce && timed_out && !is_write_reg);
  syntax_c: cover property (ce && state_reg == S_CHECK && var_reg != '0 && !type_ok);
endmodule : variable_transfer_areas
`default_nettype wire

//--- verilog/transfer_areas_pkg.sv
`default_nettype none
package transfer_areas_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] RD_DEF_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] WR_DEF_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h00C;
  localparam logic [ADDR_W-1:0] MEM_OFS = 12'h400;
  localparam int CTRL_START_RD_BIT = 0;
  localparam int CTRL_START_WR_BIT = 1;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_SYNTAX_BIT = 1;
  localparam int STATUS_COMM_BIT = 2;
  localparam int STATUS_CODE_LSB = 16;
  localparam logic [5:0] DEF_COUNT = 6'h00;
  localparam logic [5:0] DEF_OPCMD = 6'h01;
  localparam logic [5:0] DEF_AREA = 6'h02;
  localparam logic [5:0] AREA_MONITOR = 6'h00;
  localparam logic [5:0] AREA_STATUS = 6'h01;
  localparam logic [5:0] AREA_SPAN = 6'h1A;
  localparam logic [15:0] TYPE_MIN = 16'h00C0;
  localparam logic [15:0] TYPE_MAX = 16'h00CF;
  localparam logic [15:0] RD_COUNT_MIN = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'h0012;
  localparam logic [15:0] OPCMD_OFF = 16'h0000;
  localparam logic [15:0] OPCMD_ON = 16'h0001;
  localparam logic [15:0] CODE_OK = 16'h0000;
  localparam logic [15:0] CODE_TIMEOUT = 16'hE999;
  localparam logic [7:0] ERR_PREFIX = 8'hFF;
  localparam logic [7:0] END_OK = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMEOUT_NS = 1_000_000;
  localparam int TIMEOUT_CYCLES = TIMEOUT_NS / CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    S_IDLE, S_CHECK, S_ISSUE, S_WAIT, S_STORE_LO, S_STORE_HI, S_ZERO, S_MONITOR
  } state_type;

  function automatic logic is_bcd(input logic [15:0] d);
    is_bcd = (d[15:12] <= 4'h9) && (d[11:8] <= 4'h9) && (d[7:4] <= 4'h9) && (d[3:0] <= 4'h9);
  endfunction : is_bcd

  function automatic logic [15:0] bcd_to_bin(input logic [15:0] d);
    bcd_to_bin = 16'(d[15:12] * 1000 + d[11:8] * 100 + d[7:4] * 10 + d[3:0]);
  endfunction : bcd_to_bin
endpackage : transfer_areas_pkg
`default_nettype wire

//--- verification/component_model.sv
`default_nettype none
module component_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic [1:0] fail_kind,
  input wire logic [15:0] fail_at,
  input wire logic [15:0] fail_val,
  input wire logic comp_req_valid,
  output logic comp_req_ready,
  input wire logic comp_req_write,
  input wire logic comp_req_opcmd,
  input wire logic [7:0] comp_req_type,
  input wire logic [15:0] comp_req_addr,
  input wire logic [31:0] comp_req_data,
  output logic comp_rsp_valid,
  output logic [7:0] comp_rsp_end_code,
  output logic [15:0] comp_rsp_code,
  output logic [15:0] comp_rsp_status,
  output logic [31:0] comp_rsp_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] n_reg;
  logic [15:0] addr_reg;
  logic [2:0] wait_reg;
  logic [1:0] tick_reg;
  logic busy_reg;
  logic [57:0] log_reg [0:255];
  wire logic fail_now = (n_reg == fail_at) && (fail_kind != 2'h0);
  // Answer lines flip every cycle outside the pulse, so a stale value is never read as an answer.
  always_ff @(posedge aclk) begin
    tick_reg <= tick_reg + 2'h1;
    comp_rsp_valid <= 1'b0;
    {comp_rsp_end_code, comp_rsp_code, comp_rsp_status, comp_rsp_data} <=
      ~{comp_rsp_end_code, comp_rsp_code, comp_rsp_status, comp_rsp_data};
    if (!aresetn) begin
      n_reg <= '0;
      tick_reg <= '0;
      busy_reg <= 1'b0;
      comp_req_ready <= 1'b0;
      {comp_rsp_end_code, comp_rsp_code, comp_rsp_status, comp_rsp_data} <= '0;
    end else if (busy_reg) begin
      wait_reg <= wait_reg - 3'h1;
      if (wait_reg == 3'h1) begin
        busy_reg <= 1'b0;
        n_reg <= n_reg + 16'h1;
        comp_rsp_valid <= !(fail_now && fail_kind == 2'h3);
        comp_rsp_end_code <= (fail_now && fail_kind == 2'h1) ? fail_val[7:0] : 8'h00;
        comp_rsp_code <= (fail_now && fail_kind == 2'h2) ? fail_val : 16'h0000;
        comp_rsp_status <= {8'h5A, n_reg[7:0]};
        comp_rsp_data <= {addr_reg ^ 16'h3C5A, ~addr_reg};
      end
    end else if (comp_req_valid && comp_req_ready) begin
      busy_reg <= 1'b1;
      comp_req_ready <= 1'b0;
      wait_reg <= slow ? 3'h6 : 3'h1;
      addr_reg <= comp_req_addr;
      log_reg[n_reg[7:0]] <= {comp_req_write, comp_req_opcmd, comp_req_type, comp_req_addr, comp_req_data};
    end else begin
      comp_req_ready <= !slow || (tick_reg == 2'h3);
    end
  end
endmodule : component_model
`default_nettype wire

//--- verification/component_variable_transfer_areas_tb.sv
`default_nettype none
module component_variable_transfer_areas_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import transfer_areas_pkg::*;
  localparam int RD = 16;
  localparam int WR = 80;
  localparam int RA = 50;
  localparam int WA = 120;
  localparam logic [7:0] ECODE [11] = '{8'h10, 8'h11, 8'h13, 8'h04, 8'h0D, 8'h12, 8'h14, 8'h15, 8'h16, 8'h18, 8'h97};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, comp_req_data, comp_rsp_data;
  logic comp_req_valid, comp_req_ready, comp_req_write, comp_req_opcmd, comp_rsp_valid;
  logic [7:0] comp_req_type, comp_rsp_end_code;
  logic [15:0] comp_req_addr, comp_rsp_code, comp_rsp_status;
  logic slow = 1'b0;
  logic [1:0] fail_kind = 2'h0;
  logic [15:0] fail_at = '0, fail_val = '0;
  logic [31:0] lfsr = 32'h3938;
  logic [15:0] ty [1:12], ad [1:12], lo [1:12], hi [1:12];
  int mismatches = 0, checks = 0;
  always #5 aclk = ~aclk;
  // The timeout is shortened so the no-answer case finishes quickly.
  variable_transfer_areas #(.TIMEOUT(20)) variable_transfer_areas_inst (.*);
  component_model component_model_inst (.*);
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  function automatic logic [15:0] to_bcd(input int v);
    return {8'h00, 4'(v / 10), 4'(v % 10)};
  endfunction : to_bcd
  task automatic fail(input string m);
    mismatches++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail
  task automatic cmp(input logic [63:0] g, e, input string m);
    checks++;
    if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
  endtask : cmp
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string m);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    cmp(d, e, m);
  endtask : rd_chk
  task automatic mem_wr(input int i, input logic [15:0] v);
    logic [1:0] r;
    axi_wr(MEM_OFS + 12'(4 * i), {16'h0, v}, r);
    cmp(r, RESP_OKAY, "memory write response");
  endtask : mem_wr
  task automatic mem_chk(input int i, input logic [15:0] v, input string m);
    rd_chk(MEM_OFS + 12'(4 * i), {16'h0, v}, m);
  endtask : mem_chk
  task automatic rand_vars();
    for (int i = 1; i <= 12; i++) begin
      ty[i] = TYPE_MIN | 16'(rnd() & 32'hF);
      ad[i] = 16'(rnd());
      lo[i] = 16'(rnd());
      hi[i] = 16'(rnd());
    end
  endtask : rand_vars
  task automatic def_list(input int base, input logic [15:0] cnt, op, area, input int nv);
    mem_wr(base, cnt);
    mem_wr(base + 1, op);
    mem_wr(base + 2, area);
    for (int i = 1; i <= nv; i++) begin
      mem_wr(base + 1 + 2 * i, ty[i]);
      mem_wr(base + 2 + 2 * i, ad[i]);
    end
  endtask : def_list
  task automatic run(input int bitn, output logic [31:0] st);
    logic [1:0] r;
    axi_wr(CTRL_OFS, 32'(1) << bitn, r);
    for (int t = 0; t < 300; t++) begin
      axi_rd(STATUS_OFS, st, r);
      if (st[STATUS_BUSY_BIT] === 1'b0) break;
    end
    if (st[STATUS_BUSY_BIT] !== 1'b0) fail("transfer hang");
  endtask : run
  task automatic rd_test(input int c, k, input logic [1:0] kind, input logic [15:0] val, mon);
    logic [31:0] st;
    int b;
    b = component_model_inst.n_reg;
    for (int i = 0; i < 26; i++) mem_wr(RA + i, 16'hBEEF);
    def_list(RD, to_bcd(c), 16'h0000, 16'h0050, c);
    fail_kind <= kind;
    fail_at <= 16'(b + k - 1);
    fail_val <= val;
    run(CTRL_START_RD_BIT, st);
    fail_kind <= 2'h0;
    cmp(st[31:16], mon, "read status code");
    mem_chk(RA, mon, "read monitor");
    mem_chk(RA + 1, (k == 1 && kind != 2'h2) ? 16'hBEEF :
      {8'h5A, 8'(b + (k == 0 ? c : k - int'(kind != 2'h2)) - 1)}, "status word");
    for (int i = 1; i <= c; i++) begin
      if (i <= (k > 0 ? k : c)) cmp(component_model_inst.log_reg[8'(b + i - 1)], {2'b00, ty[i][7:0], ad[i], 32'h0},
        "read exchange");
      mem_chk(RA + 2 * i, (k == 0 || i < k) ? ~ad[i] : 16'h0, "low word");
      mem_chk(RA + 2 * i + 1, (k == 0 || i < k) ? ad[i] ^ 16'h3C5A : 16'h0, "high word");
    end
    cmp(32'(component_model_inst.n_reg) - 32'(b), 32'(k > 0 ? k : c), "read exchange count");
    $display("read test count %0d error at %0d done", c, k);
  endtask : rd_test
  task automatic wr_test(input int c, k, input logic [15:0] op, input logic [1:0] kind, input logic [15:0] val, mon);
    logic [31:0] st;
    int b, x;
    b = component_model_inst.n_reg;
    x = k > 0 ? k : c;
    mem_wr(WA, 16'hBEEF);
    mem_wr(WA + 1, 16'h0A5C);
    for (int i = 1; i <= c; i++) begin
      mem_wr(WA + 2 * i, lo[i]);
      mem_wr(WA + 2 * i + 1, hi[i]);
    end
    def_list(WR, to_bcd(c), op, 16'h0120, c);
    fail_kind <= kind;
    fail_at <= 16'(b + k - 1);
    fail_val <= val;
    run(CTRL_START_WR_BIT, st);
    fail_kind <= 2'h0;
    cmp(st[31:16], mon, "write status code");
    mem_chk(WA, mon, "write monitor");
    cmp(32'(component_model_inst.n_reg) - 32'(b), 32'(x + (k > 0 ? 0 : int'(op[0]))), "write count");
    for (int i = 1; i <= x; i++) cmp(component_model_inst.log_reg[8'(b + i - 1)],
      {2'b10, ty[i][7:0], ad[i], hi[i], lo[i]}, "write exchange");
    if (op[0] && k == 0) cmp(component_model_inst.log_reg[8'(b + c)], {2'b11, 24'h0, 32'h0000_0A5C},
      "command exchange");
    $display("write test count %0d error at %0d done", c, k);
  endtask : wr_test
  task automatic syn(input bit rd, input int idx, input logic [15:0] v);
    logic [31:0] st;
    int b;
    b = component_model_inst.n_reg;
    def_list(rd ? RD : WR, 16'h0003, rd ? 16'h0000 : 16'h0001, rd ? 16'h0050 : 16'h0120, 3);
    mem_wr(rd ? RA : WA, 16'hBEEF);
    mem_wr((rd ? RD : WR) + idx, v);
    run(rd ? CTRL_START_RD_BIT : CTRL_START_WR_BIT, st);
    cmp(st[STATUS_SYNTAX_BIT], 1'b1, "syntax flag");
    cmp(32'(component_model_inst.n_reg) - 32'(b), 32'h0, "exchanges after bad list");
    mem_chk(rd ? RA : WA, 16'hBEEF, "monitor after bad list");
    $display("bad list test value %h done", v);
  endtask : syn
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #500_000;
    fail("watchdog expired");
    give_verdict();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int c;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(STATUS_OFS, 32'h0, "status after reset");
    axi_rd(12'h100, d, r);
    cmp(r, RESP_DECERR, "unmapped read response");
    cmp(d, 32'h0, "unmapped read data");
    axi_wr(RD_DEF_OFS, 32'(RD), r);
    axi_wr(WR_DEF_OFS, 32'(WR), r);
    $display("reset and register test done");
    rand_vars();
    ty[1] = TYPE_MIN;
    ty[12] = TYPE_MAX;
    ad[12] = 16'hFFFF;
    rd_test(1, 0, 2'h0, 16'h0, CODE_OK);
    slow <= 1'b1;
    rd_test(12, 0, 2'h0, 16'h0, CODE_OK);
    wr_test(12, 0, 16'h0001, 2'h0, 16'h0, CODE_OK);
    slow <= 1'b0;
    foreach (ECODE[i]) begin
      rand_vars();
      c = 1 + int'(rnd() % 32'd12);
      rd_test(c, 1 + int'(rnd() % 32'(c)), 2'h1, {8'h00, ECODE[i]}, {ERR_PREFIX, ECODE[i]});
    end
    rd_test(5, 3, 2'h2, 16'h0401, 16'h0401);
    rd_test(4, 1, 2'h2, 16'h2203, 16'h2203);
    rd_test(3, 2, 2'h3, 16'h0, CODE_TIMEOUT);
    wr_test(0, 0, 16'h0001, 2'h0, 16'h0, CODE_OK);
    wr_test(0, 0, 16'h0000, 2'h0, 16'h0, CODE_OK);
    wr_test(3, 0, 16'h0000, 2'h0, 16'h0, CODE_OK);
    wr_test(4, 2, 16'h0001, 2'h1, 16'h0013, 16'hFF13);
    wr_test(2, 2, 16'h0001, 2'h2, 16'h3003, 16'h3003);
    syn(1'b1, 0, 16'h0000);
    syn(1'b1, 0, 16'h0013);
    syn(1'b1, 0, 16'h000A);
    syn(1'b0, 3, 16'h00BF);
    syn(1'b0, 5, 16'h00D0);
    syn(1'b0, 1, 16'h0002);
    give_verdict();
  end
endmodule : component_variable_transfer_areas_tb
`default_nettype wire
